// ==== rtl/fql_pkg.sv ====
// Purpose: Constants for the quick link startup configuration loader
// Assumes: 125 MHz pclk, APB register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package fql_pkg;
  // Register offsets
  localparam logic [7:0] FQL_CTRL_OFF = 8'h00;
  localparam logic [7:0] FQL_STAT_OFF = 8'h04;
  localparam logic [7:0] FQL_PHYCFG_OFF = 8'h08;
  // Switch bit positions
  localparam int FQL_SW_P1_BIT = 1;
  localparam int FQL_SW_P2_BIT = 2;
  // Status field positions
  localparam int FQL_ST_P1_EN = 0;
  localparam int FQL_ST_P2_EN = 1;
  localparam int FQL_ST_DONE = 2;
  localparam int FQL_ST_P1_CFG = 3;
  localparam int FQL_ST_P2_CFG = 4;
  localparam int FQL_ST_RUN = 5;
  // Control field positions
  localparam int FQL_CT_START = 0;
  // PHY setting word fields: bit0 autoneg off, bit1 clock master
  localparam int FQL_PC_ANEG_OFF = 0;
  localparam int FQL_PC_MASTER = 1;
  // Request words: slave is autoneg off only, master adds the role bit
  localparam logic [1:0] FQL_CFG_SLV = 2'h1;
  localparam logic [1:0] FQL_CFG_MST = 2'h3;
  // Request port codes
  localparam logic FQL_PORT_ONE = 1'b0;
  localparam logic FQL_PORT_TWO = 1'b1;
  // Last count of the synchroniser settling wait
  localparam logic [1:0] FQL_SETTLE_LAST = 2'h3;
  localparam int FQL_LOSS_MIN_MS = 400;
  localparam int FQL_LOSS_MAX_MS = 800;
  localparam int FQL_CLK_KHZ = 125000;
  localparam int FQL_LOSS_MIN_CYC = FQL_LOSS_MIN_MS * FQL_CLK_KHZ;
  // Loader states
  typedef enum logic [2:0] {
    FQL_IDLE = 3'b000,
    FQL_CAPT = 3'b001,
    FQL_SLV = 3'b010,
    FQL_MST = 3'b011,
    FQL_DONE = 3'b100
  } fql_state_t;
endpackage : fql_pkg

// ==== rtl/fql_sync.sv ====
// Purpose: Three-stage synchroniser for the option switch
// Assumes: Input is asynchronous to pclk
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module fql_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // Accept each bit when last two stages agree
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // Shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule : fql_sync
`default_nettype wire

// ==== rtl/fql_loader.sv ====
// Purpose: Quick link startup loader for a two-port gigabit station
// Assumes: APB slave registers, PHY settings written over a valid/ack handshake port
// Notes: Switch is captured once after reset release
//
// Summary of operation
// - Switch bit 1 enables port one
// - Switch bit 2 enables port two
// - Capture switch once at startup
// - Load PHY settings before normal operation
// - Bypass autonegotiation on enabled ports
// - Port one master, port two slave
// - Configure slave port before master port
// - Enabled port needs matching partner setting
// - Partner waits for link loss detection
`timescale 1ns/10ps
`default_nettype none
module fql_loader #(
  parameter int SW_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SW_W-1:0] quick_link_option_switch,
  output logic phy_cfg_valid,
  output logic phy_cfg_port,
  output logic [1:0] phy_cfg_data,
  input wire logic phy_cfg_ack,
  output logic port_one_quick_link_enable,
  output logic port_two_quick_link_enable,
  output logic normal_run
);
  logic [SW_W-1:0] sw_sync;
  fql_pkg::fql_state_t st_q, st_d;
  logic p1_q, p1_d, p2_q, p2_d;
  logic cfg1_q, cfg1_d, cfg2_q, cfg2_d;
  logic vld_q, vld_d, port_q, port_d, run_q, run_d;
  logic [1:0] cdat_q, cdat_d;
  logic [1:0] wait_q, wait_d;
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic start_q, start_d;
  logic acc;

  fql_sync #(.W(SW_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(quick_link_option_switch),
    .sync_out(sw_sync)
  );

  assign acc = psel && penable && !rdy_q;

  // Loader sequence and APB next state
  always_comb begin
    st_d = st_q;
    p1_d = p1_q;
    p2_d = p2_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    vld_d = vld_q;
    port_d = port_q;
    cdat_d = cdat_q;
    run_d = run_q;
    wait_d = wait_q;
    start_d = start_q;
    rd_d = rd_q;
    rdy_d = 1'b0;
    err_d = 1'b0;
    case (st_q)
      fql_pkg::FQL_IDLE: begin
        // Let synchroniser settle before capture
        if (wait_q == fql_pkg::FQL_SETTLE_LAST) begin
          st_d = fql_pkg::FQL_CAPT;
        end else begin
          wait_d = wait_q + 2'h1;
        end
      end
      fql_pkg::FQL_CAPT: begin
        p1_d = sw_sync[fql_pkg::FQL_SW_P1_BIT];
        p2_d = sw_sync[fql_pkg::FQL_SW_P2_BIT];
        st_d = fql_pkg::FQL_SLV;
      end
      fql_pkg::FQL_SLV: begin
        if (!p2_q) begin
          st_d = fql_pkg::FQL_MST;
        end else if (vld_q && phy_cfg_ack) begin
          vld_d = 1'b0;
          cfg2_d = 1'b1;
          st_d = fql_pkg::FQL_MST;
        end else if (!vld_q) begin
          vld_d = 1'b1;
          port_d = fql_pkg::FQL_PORT_TWO;
          cdat_d = fql_pkg::FQL_CFG_SLV;
        end
      end
      fql_pkg::FQL_MST: begin
        if (!p1_q) begin
          st_d = fql_pkg::FQL_DONE;
        end else if (vld_q && phy_cfg_ack) begin
          vld_d = 1'b0;
          cfg1_d = 1'b1;
          st_d = fql_pkg::FQL_DONE;
        end else if (!vld_q) begin
          vld_d = 1'b1;
          port_d = fql_pkg::FQL_PORT_ONE;
          cdat_d = fql_pkg::FQL_CFG_MST;
        end
      end
      fql_pkg::FQL_DONE: begin
        // Run only after loading, on software start
        if (start_q) begin
          run_d = 1'b1;
        end
      end
      default: begin
        st_d = fql_pkg::FQL_IDLE;
      end
    endcase
    // APB access, one wait state
    if (acc) begin
      rdy_d = 1'b1;
      rd_d = '0;
      case (paddr)
        fql_pkg::FQL_CTRL_OFF: begin
          rd_d[fql_pkg::FQL_CT_START] = start_q;
        end
        fql_pkg::FQL_STAT_OFF: begin
          rd_d[fql_pkg::FQL_ST_P1_EN] = p1_q;
          rd_d[fql_pkg::FQL_ST_P2_EN] = p2_q;
          rd_d[fql_pkg::FQL_ST_DONE] = (st_q == fql_pkg::FQL_DONE);
          rd_d[fql_pkg::FQL_ST_P1_CFG] = cfg1_q;
          rd_d[fql_pkg::FQL_ST_P2_CFG] = cfg2_q;
          rd_d[fql_pkg::FQL_ST_RUN] = run_q;
        end
        fql_pkg::FQL_PHYCFG_OFF: begin
          rd_d[fql_pkg::FQL_PC_ANEG_OFF] = cdat_q[fql_pkg::FQL_PC_ANEG_OFF];
          rd_d[fql_pkg::FQL_PC_MASTER] = cdat_q[fql_pkg::FQL_PC_MASTER];
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
    end
    // Write lands at the edge where pready is seen high
    if (psel && penable && rdy_q && pwrite && (paddr == fql_pkg::FQL_CTRL_OFF)) begin
      start_d = pwdata[fql_pkg::FQL_CT_START];
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fql_pkg::FQL_IDLE;
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      cfg1_q <= 1'b0;
      cfg2_q <= 1'b0;
      vld_q <= 1'b0;
      port_q <= 1'b0;
      cdat_q <= 2'h0;
      run_q <= 1'b0;
      wait_q <= 2'h0;
      start_q <= 1'b0;
      rd_q <= 32'h0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      vld_q <= vld_d;
      port_q <= port_d;
      cdat_q <= cdat_d;
      run_q <= run_d;
      wait_q <= wait_d;
      start_q <= start_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // Outputs straight from registers
  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign phy_cfg_valid = vld_q;
  assign phy_cfg_port = port_q;
  assign phy_cfg_data = cdat_q;
  assign port_one_quick_link_enable = p1_q;
  assign port_two_quick_link_enable = p2_q;
  assign normal_run = run_q;

  AST_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q != fql_pkg::FQL_IDLE && st_q != fql_pkg::FQL_CAPT) |=> $stable(p1_q) && $stable(p2_q))
    else $error("enable changed after capture");
  AST_P1_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == fql_pkg::FQL_CAPT |=> p1_q == $past(sw_sync[fql_pkg::FQL_SW_P1_BIT]))
    else $error("port one enable wrong");
  AST_P2_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == fql_pkg::FQL_CAPT |=> p2_q == $past(sw_sync[fql_pkg::FQL_SW_P2_BIT]))
    else $error("port two enable wrong");
  AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    (vld_q && !port_q) |-> (cfg2_q || !p2_q))
    else $error("master configured before slave");
  AST_ROLE: assert property (@(posedge pclk) disable iff (!presetn)
    vld_q |-> cdat_q[fql_pkg::FQL_PC_MASTER] == (port_q == fql_pkg::FQL_PORT_ONE))
    else $error("wrong clock role");
  AST_ANEG: assert property (@(posedge pclk) disable iff (!presetn)
    vld_q |-> cdat_q[fql_pkg::FQL_PC_ANEG_OFF])
    else $error("autonegotiation not bypassed");
  AST_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    run_q |-> (st_q == fql_pkg::FQL_DONE && cfg1_q == p1_q && cfg2_q == p2_q))
    else $error("run before settings loaded");
  AST_NOLOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == fql_pkg::FQL_SLV && !p2_q) |=> st_q == fql_pkg::FQL_MST && !vld_q)
    else $error("disabled port loaded");
endmodule : fql_loader
`default_nettype wire

// ==== tb/fql_phy_model.sv ====
// Purpose: Far-side PHY model taking the quick link setting requests
// Assumes: Requests stand until acknowledged
// Notes: Ack delay is chosen per test, zero gives the quickest answer
`timescale 1ns/10ps
`default_nettype none
module fql_phy_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cfg_valid,
  input wire logic [3:0] delay,
  output logic cfg_ack
);
  logic [3:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_valid && !cfg_ack && (cnt_q >= delay);
      cnt_q <= (cfg_valid && !cfg_ack) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : fql_phy_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the quick link loader
// Assumes: One reset per table row, PHY model acks after a set delay
// Notes: Rows hold {switch, port two enable, port one enable}
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cv, cp, ack, p1, p2, run;
  logic [1:0] cd;
  logic [3:0] sw = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [2:0] seen[$];
  // Single-port rows stand for chain ends
  logic [5:0] rows[6] = '{6'h00, 6'h09, 6'h12, 6'h1b, 6'h24, 6'h3f};
  int n_fail = 0;
  int n_checks = 0;

  // Clock
  always #4 pclk = ~pclk;

  fql_loader #(.SW_W(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quick_link_option_switch(sw), .phy_cfg_valid(cv), .phy_cfg_port(cp),
    .phy_cfg_data(cd), .phy_cfg_ack(ack), .port_one_quick_link_enable(p1),
    .port_two_quick_link_enable(p2), .normal_run(run));

  fql_phy_model phy (.pclk(pclk), .presetn(presetn), .cfg_valid(cv),
    .delay(dly), .cfg_ack(ack));

  // Log accepted requests as {port, data}
  always @(posedge pclk) if (cv === 1'b1 && ack === 1'b1) seen.push_back({cp, cd});

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
    @(posedge pclk);
  endtask : apb

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    seen = {};
    @(posedge pclk);
  endtask : do_reset

  task automatic run_row(input logic [5:0] r, input logic [3:0] d);
    int k;
    logic [2:0] expq[$];
    k = 0;
    sw <= r[5:2];
    dly <= d;
    do_reset();
    if (r[1]) expq.push_back(3'b101);
    if (r[0]) expq.push_back(3'b011);
    do begin
      apb(1'b0, fql_pkg::FQL_STAT_OFF, 32'h0);
      k++;
    end while (rd[2] !== 1'b1 && k < 40);
    if (rd[2] !== 1'b1) begin
      n_fail++;
      final_report();
    end
    chk("stat", {26'h0, 1'b0, r[1:0], 1'b1, r[1:0]}, rd);
    chk("serr", 32'h0, {31'h0, err});
    chk("nreq", expq.size(), seen.size());
    foreach (expq[j]) chk("req", {29'h0, expq[j]}, {29'h0, seen[j]});
    sw <= ~r[5:2];
    repeat (12) @(posedge pclk);
    chk("p1", {31'h0, r[0]}, {31'h0, p1});
    chk("p2", {31'h0, r[1]}, {31'h0, p2});
    chk("run0", 32'h0, {31'h0, run});
    apb(1'b1, fql_pkg::FQL_CTRL_OFF, 32'h1);
    @(posedge pclk);
    chk("run1", 32'h1, {31'h0, run});
    apb(1'b0, fql_pkg::FQL_CTRL_OFF, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, fql_pkg::FQL_PHYCFG_OFF, 32'h0);
    chk("last", r[0] ? 32'h3 : {31'h0, r[1]}, rd);
  endtask : run_row

  // Table rows, then reset in mid-load, refusals
  initial begin
    for (int i = 0; i < 6; i++) run_row(rows[i], 4'(i));
    sw <= 4'h6;
    dly <= 4'hf;
    do_reset();
    repeat (9) @(posedge pclk);
    chk("mid", 32'h1, {31'h0, cv});
    presetn <= 1'b0;
    @(posedge pclk);
    chk("rst", 32'h0, {28'h0, cv, p1, p2, run});
    run_row(6'h1b, 4'h2);
    apb(1'b0, 8'h0c, 32'h0);
    chk("uerr", 32'h1, {31'h0, err});
    chk("urd", 32'h0, rd);
    apb(1'b1, fql_pkg::FQL_STAT_OFF, 32'h0);
    apb(1'b0, fql_pkg::FQL_STAT_OFF, 32'h0);
    chk("stro", 32'h3f, rd);
    final_report();
  end
endmodule : tb
`default_nettype wire
